// file: core/rled_defines.vh
// Field positions and codes for the lower remap entry decode.
// Assumes inclusion by rled_*.v files only.
`ifndef RLED_DEFINES_VH
`define RLED_DEFINES_VH
`define RLED_PRESENT_BIT      0
`define RLED_SPARE_HI         11
`define RLED_SPARE_LO         8
`define RLED_RSVDA_HI         14
`define RLED_RSVDA_LO         12
`define RLED_MODE_BIT         15
`define RLED_VEC_HI           23
`define RLED_VEC_LO           16
`define RLED_RSVDB_HI         31
`define RLED_RSVDB_LO         24
`define RLED_DST_HI           63
`define RLED_DST_LO           32
`define RLED_DST8_HI          47
`define RLED_DST8_LO          40
`define RLED_SID_HI           79
`define RLED_SID_LO           64
`define RLED_SQ_HI            81
`define RLED_SQ_LO            80
`define RLED_SVT_HI           83
`define RLED_SVT_LO           82
`define RLED_SVT_NONE         2'h0
`define RLED_SVT_FULL         2'h1
`define RLED_SVT_BUS          2'h2
`define RLED_SVT_RSVD         2'h3
`endif

// file: core/rled_sid_check.v
// Source identifier check against an incoming requester id.
// Assumes entry fields and requester id are stable in the request cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rled_defines.vh"
module rled_sid_check (
   input  wire [15:0] sourceIdentifier,      // Entry source id
   input  wire [1:0]  sourceValidationType,  // Validation type
   input  wire [1:0]  sourceQualifier,       // Compare qualifier
   input  wire [15:0] requesterId,           // Incoming requester id
   output reg         sidOk,                 // Check passed
   output reg         svtBad                 // Reserved type used
);
   function [15:0] qualMask;
      input [1:0] q;
      begin
         case (q)
            2'h0:    qualMask = 16'hffff;   // [RULE13]
            2'h1:    qualMask = 16'hfffb;
            2'h2:    qualMask = 16'hfff9;
            default: qualMask = 16'hfff8;
         endcase
      end
   endfunction

   wire [7:0] startBus = sourceIdentifier[15:8];  // [RULE3]
   wire [7:0] endBus   = sourceIdentifier[7:0];
   wire [7:0] reqBus   = requesterId[15:8];
   wire [15:0] mask    = qualMask(sourceQualifier);  // [RULE2]

   always @* begin
      svtBad = 1'b0;
      case (sourceValidationType)  // [RULE12]
         `RLED_SVT_NONE: sidOk = 1'b1;
         `RLED_SVT_FULL: sidOk = ((sourceIdentifier ^ requesterId) & mask) == 16'h0000; // [RULE1]
         `RLED_SVT_BUS:  sidOk = (reqBus >= startBus) && (reqBus <= endBus); // [RULE3]
         default: begin
            sidOk  = 1'b0;
            svtBad = 1'b1;
         end
      endcase
   end
endmodule // rled_sid_check
`default_nettype wire

// file: core/rled_remap_entry_decode.v
// Decode and check of the lower remap entry fields for remapped interrupts.
// Assumes entry and request arrive together on one sys_clk cycle with reqValid.
// Answers are registered and come one clock after the request.
// Fault codes: 1 entry absent, 2 source check failed, 3 reserved bits or type.
// How it works
// [RULE1] Full check treats the source identifier as the permitted requester id.
// [RULE2] In full check, the qualifier picks which source bits are compared.
// [RULE3] Bus range: high byte start bus, low byte end bus, inclusive.
// [RULE4] Source identifier used only when present and type is full or range.
// [RULE5] Destination taken from destination field, only for present entries.
// [RULE6] Legacy mode: 8-bit destination at 47:40, rest of 63:32 must be zero.
// [RULE7] Extended mode: all of 63:32 is the destination.
// [RULE8] Bits 31:24 and 14:12 must be zero, checked only when present.
// [RULE9] Vector from bits 23:16, taken only for present entries.
// [RULE10] Bit 15 zero remaps; one means posted layout is used.
// [RULE11] Software spare bits 11:8 are ignored entirely.
// [RULE12] Type 00 none, 01 qualified, 10 bus range, 11 reserved.
// [RULE13] Qualifier masks low bits 2, 2:1 or 2:0; upper 13 always compared.
// [RULE14] Failed or malformed requests are blocked and a fault pulse raised.
`timescale 1ns/1ps
`default_nettype none
`include "rled_defines.vh"
module rled_remap_entry_decode (
   input  wire         sys_clk,                    // 40 MHz clock
   input  wire         srst,                       // Sync reset, active high
   input  wire         reqValid,                   // Request strobe
   input  wire [15:0]  requesterId,                // Incoming requester id
   input  wire [127:0] interrupt_remap_entry,      // Fetched entry
   input  wire         extended_destination_enable, // Extended destination mode
   output reg          outValid,                   // Remapped interrupt pulse
   output reg  [31:0]  outDestination,             // Target destination id
   output reg  [7:0]   outVector,                  // Interrupt vector
   output reg          postedValid,                // Request for posted path
   output reg          remapFault,                 // Fault pulse
   output reg  [2:0]   faultCause                  // 1 absent,2 source,3 reserved
);
   wire present = interrupt_remap_entry[`RLED_PRESENT_BIT];
   wire [15:0] source_identifier = interrupt_remap_entry[`RLED_SID_HI:`RLED_SID_LO];
   wire [1:0]  source_validation_type = interrupt_remap_entry[`RLED_SVT_HI:`RLED_SVT_LO];
   wire [1:0]  source_qualifier = interrupt_remap_entry[`RLED_SQ_HI:`RLED_SQ_LO];
   wire [31:0] destination_field = interrupt_remap_entry[`RLED_DST_HI:`RLED_DST_LO];
   wire        remap_or_post_select = interrupt_remap_entry[`RLED_MODE_BIT];
   wire        sidOk;
   wire        svtBad;
   wire [7:0]  vectorField = interrupt_remap_entry[`RLED_VEC_HI:`RLED_VEC_LO];
   wire [31:0] rsvdLowHit;      // Low reserved bits as found
   wire [31:0] dstRsvdHit;      // Legacy reserved destination bits as found
   wire        lowFieldsDirty;
   wire        legacyDstDirty;
   reg         rsvdBad;
   reg  [31:0] dstDecoded;
   reg         srcOk;
   reg  [1:0]  verdict;
   reg  [2:0]  causeNext;
   genvar      gi;
   genvar      gj;

   // Outcome of one request
   localparam [1:0] VERDICT_NONE  = 2'b00;
   localparam [1:0] VERDICT_REMAP = 2'b01;
   localparam [1:0] VERDICT_POST  = 2'b10;
   localparam [1:0] VERDICT_FAULT = 2'b11;

   // Fault codes held on faultCause
   localparam [2:0] CAUSE_ABSENT = 3'b001;
   localparam [2:0] CAUSE_SOURCE = 3'b010;
   localparam [2:0] CAUSE_RSVD   = 3'b011;

   // Only types 01 and 10 read the source identifier
   function svtChecksSource;
      input [1:0] t;
      begin
         svtChecksSource = (t == `RLED_SVT_FULL) || (t == `RLED_SVT_BUS);
      end
   endfunction

   // Destination as delivered in the current destination mode
   function [31:0] pickDestination;
      input        wide;
      input [31:0] fld;
      begin
         if (wide) begin
            pickDestination = fld;  // [RULE7]
         end else begin
            pickDestination = {24'h000000,
                               fld[`RLED_DST8_HI-`RLED_DST_LO:`RLED_DST8_LO-`RLED_DST_LO]}; // [RULE6]
         end
      end
   endfunction

   rled_sid_check uSid (
      .sourceIdentifier     (source_identifier),
      .sourceValidationType (source_validation_type),
      .sourceQualifier      (source_qualifier),
      .requesterId          (requesterId),
      .sidOk                (sidOk),
      .svtBad               (svtBad)
   );

   // Per-bit detectors for reserved bits 31:24 and 14:12
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_low
         if (((gi >= `RLED_RSVDB_LO) && (gi <= `RLED_RSVDB_HI)) ||
             ((gi >= `RLED_RSVDA_LO) && (gi <= `RLED_RSVDA_HI))) begin : g_rsvd
            assign rsvdLowHit[gi] = interrupt_remap_entry[gi];  // [RULE8]
         end else begin : g_used
            // Spare bits 11:8 land here and are never read
            assign rsvdLowHit[gi] = 1'b0;  // [RULE11]
         end
      end
   endgenerate

   // Legacy mode keeps only destination bits 47:40
   generate
      for (gj = 0; gj < 32; gj = gj + 1) begin : g_dst
         if ((gj + `RLED_DST_LO >= `RLED_DST8_LO) &&
             (gj + `RLED_DST_LO <= `RLED_DST8_HI)) begin : g_id
            assign dstRsvdHit[gj] = 1'b0;
         end else begin : g_zero
            assign dstRsvdHit[gj] = destination_field[gj];  // [RULE6]
         end
      end
   endgenerate

   assign lowFieldsDirty = |rsvdLowHit;  // [RULE8]
   assign legacyDstDirty = |dstRsvdHit;  // [RULE6]

   // Destination in the current mode
   always @* begin
      dstDecoded = pickDestination(extended_destination_enable, destination_field); // [RULE5]
   end

   // Reserved checks and source gate
   always @* begin
      if (remap_or_post_select) begin
         // Posted layout reuses the upper fields; only 31:24 and 14:12 apply here
         rsvdBad = lowFieldsDirty;  // [RULE8]
      end else begin
         rsvdBad = lowFieldsDirty || svtBad ||
                   (!extended_destination_enable && legacyDstDirty);  // [RULE6]
      end
      srcOk = svtChecksSource(source_validation_type) ? sidOk : 1'b1;  // [RULE4]
   end

   // Priority: absent, reserved, source, posted, remapped
   always @* begin
      verdict   = VERDICT_NONE;
      causeNext = 3'h0;
      if (reqValid) begin
         if (!present) begin  // [RULE4]
            verdict   = VERDICT_FAULT;  // [RULE14]
            causeNext = CAUSE_ABSENT;
         end else if (rsvdBad) begin
            verdict   = VERDICT_FAULT;  // [RULE14]
            causeNext = CAUSE_RSVD;
         end else if (!srcOk) begin
            verdict   = VERDICT_FAULT;  // [RULE14]
            causeNext = CAUSE_SOURCE;
         end else if (remap_or_post_select) begin
            verdict   = VERDICT_POST;  // [RULE10]
         end else begin
            verdict   = VERDICT_REMAP;  // [RULE10]
         end
      end
   end

   // One-cycle answer pulses, exactly one per request
   always @(posedge sys_clk) begin
      if (srst) begin
         outValid    <= 1'b0;
         postedValid <= 1'b0;
         remapFault  <= 1'b0;
      end else begin
         outValid    <= 1'b0;
         postedValid <= 1'b0;
         remapFault  <= 1'b0;
         case (verdict)
            VERDICT_REMAP: begin
               outValid <= 1'b1;  // [RULE10]
            end
            VERDICT_POST: begin
               postedValid <= 1'b1;  // [RULE10]
            end
            VERDICT_FAULT: begin
               remapFault <= 1'b1;  // [RULE14]
            end
            default: begin
            end
         endcase
      end
   end

   // Destination holds until the next remapped issue
   always @(posedge sys_clk) begin
      if (srst) begin
         outDestination <= 32'h00000000;
      end else if (verdict == VERDICT_REMAP) begin
         outDestination <= dstDecoded;  // [RULE5]
      end
   end

   // Vector holds until the next remapped issue
   always @(posedge sys_clk) begin
      if (srst) begin
         outVector <= 8'h00;
      end else if (verdict == VERDICT_REMAP) begin
         outVector <= vectorField;  // [RULE9]
      end
   end

   // Fault code holds until the next fault
   always @(posedge sys_clk) begin
      if (srst) begin
         faultCause <= 3'h0;
      end else if (verdict == VERDICT_FAULT) begin
         faultCause <= causeNext;  // [RULE14]
      end
   end
endmodule // rled_remap_entry_decode
`default_nettype wire

// file: test/rled_remap_entry_decode_assertions.sv
// Port checker for the lower remap entry decode.
// Assumes a bind onto rled_remap_entry_decode, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rled_entry_checker (
   input wire logic         sys_clk,                     // Clock
   input wire logic         srst,                        // Sync reset
   input wire logic         reqValid,                    // Request strobe
   input wire logic [127:0] interrupt_remap_entry,       // Entry
   input wire logic         extended_destination_enable, // Wide mode
   input wire logic         outValid,                    // Remap pulse
   input wire logic [31:0]  outDestination,              // Destination
   input wire logic [7:0]   outVector,                   // Vector
   input wire logic         postedValid,                 // Posted pulse
   input wire logic         remapFault,                  // Fault pulse
   input wire logic [2:0]   faultCause                   // Fault code
);
   wire [127:0] e  = interrupt_remap_entry;
   wire         ok = reqValid && e[0] && e[31:24] == 8'h0 && e[14:12] == 3'h0;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_remap;
      ok && !e[15] ##1 outValid;
   endsequence
   a_one_answer: assert property (
      reqValid |=> $onehot({outValid, postedValid, remapFault}))
      else $error("answer count wrong");
   a_no_answer: assert property (
      !reqValid |=> !(outValid || postedValid || remapFault))
      else $error("answer without request");
   a_absent_fault: assert property (
      reqValid && !e[0] |=> remapFault && faultCause == 3'h1)
      else $error("absent entry not faulted");
   a_rsvd_fault: assert property (
      reqValid && e[0] && !ok |=> remapFault && faultCause == 3'h3)
      else $error("reserved bits not faulted");
   a_posted_mode: assert property (
      ok && e[15] && e[83:82] == 2'h0 |=> postedValid)
      else $error("posted entry not handed on");
   a_type_rsvd: assert property (
      ok && !e[15] && e[83:82] == 2'h3 |=> faultCause == 3'h3)
      else $error("reserved type not faulted");
   a_vector_take: assert property (
      s_remap |-> outVector == $past(e[23:16]))
      else $error("vector wrong");
   a_dest_take: assert property (
      s_remap |-> outDestination == ($past(extended_destination_enable) ?
      $past(e[63:32]) : {24'h0, $past(e[47:40])})) else $error("destination wrong");
   a_fields_hold: assert property (
      !reqValid |=> $stable(outDestination) && $stable(outVector) && $stable(faultCause))
      else $error("held output changed");
endmodule // rled_entry_checker
`default_nettype wire

// file: test/rled_req_source.sv
// Requesting device model: one request per send call.
// Assumes a free-running sys_clk; drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module rled_req_source (
   input  wire logic         sys_clk,  // Clock
   output var  logic         reqValid, // Request strobe
   output var  logic [15:0]  reqId,    // Requester id
   output var  logic [127:0] reqEntry, // Entry
   output var  logic         extMode   // Wide destination
);
   initial begin
      reqValid = 1'b0;
      reqId    = 16'h0;
      reqEntry = 128'h0;
      extMode  = 1'b0;
   end
   task send(input logic [127:0] en, input logic [15:0] id, input logic x);
      @(negedge sys_clk);
      reqValid = 1'b1;
      reqEntry = en;
      reqId    = id;
      extMode  = x;
      @(negedge sys_clk);
      reqValid = 1'b0;
      reqEntry = ~reqEntry; // Idle lines do not keep old value
      reqId    = ~reqId;
   endtask
endmodule // rled_req_source
`default_nettype wire

// file: test/tb_rled_remap_entry_decode.sv
// Self-checking bench for the lower remap entry decode.
// Assumes the partner model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_rled_remap_entry_decode;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic reqValid, extMode, outValid, postedValid, remapFault;
   logic [15:0] reqId;
   logic [127:0] reqEntry;
   logic [31:0] outDestination;
   logic [7:0] outVector;
   logic [2:0] faultCause;
   int miscompares = 0;
   int testsRun = 0;
   always #12.5 sys_clk = ~sys_clk;
   rled_req_source rled_req_source_inst (.sys_clk(sys_clk), .reqValid(reqValid),
      .reqId(reqId), .reqEntry(reqEntry), .extMode(extMode));
   rled_remap_entry_decode rled_remap_entry_decode_inst (.sys_clk(sys_clk), .srst(srst),
      .reqValid(reqValid), .requesterId(reqId), .interrupt_remap_entry(reqEntry),
      .extended_destination_enable(extMode), .outValid(outValid),
      .outDestination(outDestination), .outVector(outVector), .postedValid(postedValid),
      .remapFault(remapFault), .faultCause(faultCause));
   function automatic logic [127:0] e(input logic [1:0] t, q, input logic [15:0] s,
      input logic [31:0] d);
      return {44'h0, t, q, s, d, 8'h0, d[15:8] ^ 8'h5a, 4'h0, 4'ha, 8'h1};
   endfunction
   task cmp(input logic [39:0] got, exp);
      testsRun++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // r: 0 remapped, 4 posted, else expected fault code
   task run(input logic [127:0] en, input logic [15:0] id, input logic x, input logic [2:0] r,
      input logic [31:0] d);
      rled_req_source_inst.send(en, id, x);
      cmp({outValid, postedValid, remapFault}, r == 3'h0 ? 3'h4 : r == 3'h4 ? 3'h2 : 3'h1);
      if (r == 3'h0) cmp({en[23:16], outDestination}, {outVector, d});
      else if (r != 3'h4) cmp(faultCause, r);
   endtask
   task closeOut;
      if (miscompares == 0 && testsRun > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #5000;
      miscompares++;
      closeOut;
   end
   initial begin
      repeat (20) @(negedge sys_clk);
      srst = 1'b0;
      run(e(2'h0, 2'h0, 16'hbeef, 32'h12345678), 16'h0, 1'b1, 3'h0, 32'h12345678);
      run(e(2'h0, 2'h0, 16'h0, 32'h0000ab00), 16'h0, 1'b0, 3'h0, 32'h000000ab);
      run(e(2'h0, 2'h0, 16'h0, 32'h0000cd00) | 128'h500, 16'h0, 1'b0, 3'h0, 32'h000000cd);
      run(e(2'h0, 2'h0, 16'h0, 32'h8000ab00), 16'h0, 1'b0, 3'h3, 32'h0);
      run(e(2'h0, 2'h0, 16'h0, 32'h0000ab01), 16'h0, 1'b0, 3'h3, 32'h0);
      run(e(2'h1, 2'h0, 16'h1234, 32'h1), 16'h1234, 1'b1, 3'h0, 32'h1);
      run(e(2'h1, 2'h0, 16'h1234, 32'h1), 16'h1235, 1'b1, 3'h2, 32'h0);
      run(e(2'h1, 2'h1, 16'h1230, 32'h2), 16'h1234, 1'b1, 3'h0, 32'h2);
      run(e(2'h1, 2'h1, 16'h1230, 32'h2), 16'h1232, 1'b1, 3'h2, 32'h0);
      run(e(2'h1, 2'h2, 16'h1230, 32'h3), 16'h1236, 1'b1, 3'h0, 32'h3);
      run(e(2'h1, 2'h3, 16'h1230, 32'h4), 16'h1237, 1'b1, 3'h0, 32'h4);
      run(e(2'h1, 2'h3, 16'h1230, 32'h4), 16'h123f, 1'b1, 3'h2, 32'h0);
      run(e(2'h2, 2'h0, 16'h1020, 32'h5), 16'h2000, 1'b1, 3'h0, 32'h5);
      run(e(2'h2, 2'h0, 16'h1020, 32'h6), 16'h10ff, 1'b1, 3'h0, 32'h6);
      run(e(2'h2, 2'h0, 16'h1020, 32'h6), 16'h2100, 1'b1, 3'h2, 32'h0);
      run(e(2'h2, 2'h0, 16'h1020, 32'h6), 16'h0f00, 1'b1, 3'h2, 32'h0);
      run(e(2'h2, 2'h0, 16'h2010, 32'h5), 16'h1800, 1'b1, 3'h2, 32'h0);
      run(e(2'h3, 2'h0, 16'h0, 32'h7), 16'h0, 1'b1, 3'h3, 32'h0);
      run(e(2'h0, 2'h0, 16'h0, 32'h7) | 128'h8000, 16'h0, 1'b1, 3'h4, 32'h0);
      run(e(2'h3, 2'h0, 16'h0, 32'h7) | 128'h8000, 16'h0, 1'b0, 3'h4, 32'h0);
      run(e(2'h3, 2'h0, 16'h0, 32'h7) | 128'h1008000, 16'h0, 1'b1, 3'h3, 32'h0);
      run(e(2'h1, 2'h0, 16'h1234, 32'h7) | 128'h8000, 16'h1235, 1'b1, 3'h2, 32'h0);
      run(e(2'h0, 2'h0, 16'h0, 32'h7) | 128'h1000000, 16'h0, 1'b1, 3'h3, 32'h0);
      run(e(2'h0, 2'h0, 16'h0, 32'h7) | 128'h4000, 16'h0, 1'b1, 3'h3, 32'h0);
      run(e(2'h1, 2'h0, 16'h9, 32'h7) ^ 128'h1000001, 16'h0, 1'b1, 3'h1, 32'h0);
      closeOut;
   end
endmodule // tb_rled_remap_entry_decode
bind rled_remap_entry_decode rled_entry_checker rled_entry_checker_inst (.*);
`default_nettype wire
